// ### dcr_pkg.sv
// dcr_pkg: register map, field positions, reset values and modes of one dma channel
// assumes a 32-bit ahb-lite register bus and 16-bit channel registers in the low lanes
package dcr_pkg;

  // register byte offsets (haddr[7:0])
  localparam logic [7:0]  OFS_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_REQUEST  = 8'h04;
  localparam logic [7:0]  OFS_START_A  = 8'h08;
  localparam logic [7:0]  OFS_START_B  = 8'h0c;
  localparam logic [7:0]  OFS_PERIPH   = 8'h10;
  localparam logic [7:0]  OFS_COUNT    = 8'h14;
  localparam logic [7:0]  OFS_STATUS   = 8'h18;

  // channel_control field positions
  localparam int          CTL_ENABLE   = 15;
  localparam int          CTL_BYTE     = 14;
  localparam int          CTL_TO_PER   = 13;
  localparam int          CTL_EARLY    = 12;
  localparam int          CTL_NULL_PERIPHERAL_WRITE    = 11;
  localparam int          CTL_ADDRESSING_MODE_LO = 4;
  localparam int          CTL_MODE_LO  = 0;
  localparam logic [15:0] CTL_MASK     = 16'hf833;

  // channel_request_select field positions
  localparam int          REQ_FORCE    = 15;
  localparam logic [15:0] REQ_MASK     = 16'h807f;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // count register and status layout
  localparam int          CNT_W        = 10;
  localparam int          STS_IDX_LO   = 16;

  // addressing_mode encodings
  localparam logic [1:0]  AM_POSTINC   = 2'b00;
  localparam logic [1:0]  AM_NOINC     = 2'b01;
  localparam logic [1:0]  AM_PERIPH    = 2'b10;

  // operating mode encodings
  localparam logic [1:0]  OM_CONT      = 2'b00;
  localparam logic [1:0]  OM_ONESHOT   = 2'b01;
  localparam logic [1:0]  OM_CONT_PP   = 2'b10;
  localparam logic [1:0]  OM_ONESHOT_PP = 2'b11;

  // ram address step per transfer
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;

  // one transfer handed to the memory side
  typedef struct packed {
    logic [15:0] ram_addr;
    logic [15:0] periph_addr;
    logic        to_periph;
    logic        null_write;
    logic        byte_size;
  } dcr_xfer_s;

endpackage

// ### dcr_xfer_if.sv
// dcr_xfer_if: valid/ready carrier for transfer words between channel and buffer
// assumes one clock domain; word stands while valid is high and ready low
`timescale 1ns/10ps
interface dcr_xfer_if
  import dcr_pkg::*;
  ();
  logic      valid;
  logic      ready;
  dcr_xfer_s word;

  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface

// ### dcr_skid_buf.sv
// dcr_skid_buf: two-entry buffer, an output register plus one skid slot
// assumes the sink may drop ready at any time; no word is lost when it does
`timescale 1ns/10ps
module dcr_skid_buf
  import dcr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // filling side
  dcr_xfer_if.snk  fill,
  // draining side
  dcr_xfer_if.src  drain
);

  // only the output register plus one skid slot is built
  if (DEPTH != 2) begin : g_bad_depth
    $error("dcr_skid_buf serves only DEPTH 2");
  end

  typedef struct packed {
    logic      out_valid;
    dcr_xfer_s out_word;
    logic      skid_valid;
    dcr_xfer_s skid_word;
  } dcr_buf_s;

  dcr_buf_s cur;
  dcr_buf_s next_cur;

  // ready only depends on a flop, so the filling side sees no comb path
  assign fill.ready  = ~cur.skid_valid;
  assign drain.valid = cur.out_valid;
  assign drain.word  = cur.out_word;

  // refill the output slot first from the skid slot, then from the input
  always_comb begin
    next_cur = cur;
    if (drain.ready || !cur.out_valid) begin
      if (cur.skid_valid) begin
        next_cur.out_valid  = 1'b1;
        next_cur.out_word   = cur.skid_word;
        next_cur.skid_valid = 1'b0;
      end else begin
        next_cur.out_valid  = fill.valid;
        next_cur.out_word   = fill.word;
      end
    end else if (fill.valid && !cur.skid_valid) begin
      next_cur.skid_valid = 1'b1;
      next_cur.skid_word  = fill.word;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

// ### dcr_channel.sv
// dcr_channel: one dma channel, its control and request registers and its sequencer
// assumes ahb-lite single word transfers and peripheral request lines in the clock domain
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps

module dcr_channel
  import dcr_pkg::*;
#(
  parameter int LINES = 128
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output      logic [31:0]       hrdata,
  output      logic              hreadyout,
  output      logic              hresp,
  // peripheral side
  input  wire logic [LINES-1:0]  peripheral_request_line,
  input  wire logic [15:0]       periph_index,
  // transfer output
  output      logic              xfer_valid,
  input  wire logic              xfer_ready,
  output      logic [15:0]       xfer_ram_addr,
  output      logic [15:0]       xfer_periph_addr,
  output      logic              xfer_to_periph,
  output      logic              xfer_null_write,
  output      logic              xfer_byte,
  // block interrupt pulse
  output      logic              block_irq
);

  // the selector field is seven bits wide, so no other line count can be decoded
  if (LINES != 128) begin : g_bad_lines
    $error("dcr_channel needs exactly 128 request lines");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dcr_chan_e;

  typedef struct packed {
    logic [15:0]      ctl;
    logic [15:0]      req;
    logic [15:0]      sta;
    logic [15:0]      stb;
    logic [15:0]      pad;
    logic [CNT_W-1:0] cnt;
    dcr_chan_e        st;
    logic             sec;
    logic [CNT_W-1:0] idx;
    logic [15:0]      offs;
    logic             pend;
    logic             irq;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    logic             rdy;
  } dcr_state_s;

  localparam dcr_state_s STATE_RESET = '{
    ctl: REG_RESET, req: REG_RESET, sta: REG_RESET, stb: REG_RESET, pad: REG_RESET,
    cnt: '0, st: ST_IDLE, sec: 1'b0, idx: '0, offs: '0, pend: 1'b0, irq: 1'b0,
    wr_pend: 1'b0, wr_addr: '0, rdata: '0, rdy: 1'b1
  };

  dcr_state_s cur;
  dcr_state_s next_cur;

  dcr_xfer_if push_if ();
  dcr_xfer_if out_if ();

  // field views
  logic       chen;
  logic       early;
  logic [1:0] addressing_mode;
  logic [1:0] mode;
  logic       trig;
  logic       line_hit;
  logic       push;
  logic       last;
  logic       half_pt;
  logic       addr_take;
  logic       req_wr;
  logic       ctl_wr;
  logic [15:0] wdata;
  logic [15:0] base;
  logic [15:0] step;
  logic [31:0] rd_mux;

  assign chen   = cur.ctl[CTL_ENABLE];
  assign early  = cur.ctl[CTL_EARLY];
  assign addressing_mode  = cur.ctl[CTL_ADDRESSING_MODE_LO +: 2];
  assign mode   = cur.ctl[CTL_MODE_LO +: 2];
  assign wdata  = hwdata[15:0];
  assign ctl_wr = cur.wr_pend && (cur.wr_addr == OFS_CONTROL);
  assign req_wr = cur.wr_pend && (cur.wr_addr == OFS_REQUEST);

  // selected peripheral line or the force bit starts a transfer
  assign line_hit = peripheral_request_line[cur.req[6:0]];
  assign trig     = line_hit || cur.req[REQ_FORCE];
  assign push = (cur.st == ST_RUN) && (trig || cur.pend) && push_if.ready;
  assign last = (cur.idx == cur.cnt);
  assign half_pt = (cur.idx == (cur.cnt >> 1));
  assign step = cur.ctl[CTL_BYTE] ? STEP_BYTE : STEP_WORD;
  assign base = cur.sec ? cur.stb : cur.sta;

  // transfer word; reserved addressing mode holds the address like no-increment
  always_comb begin
    push_if.valid           = push;
    push_if.word.periph_addr = cur.pad;
    push_if.word.to_periph  = cur.ctl[CTL_TO_PER];
    push_if.word.byte_size  = cur.ctl[CTL_BYTE];
    push_if.word.null_write = cur.ctl[CTL_NULL_PERIPHERAL_WRITE] && !cur.ctl[CTL_TO_PER];
    if (addressing_mode == AM_PERIPH) begin
      push_if.word.ram_addr = base + periph_index;
    end else begin
      push_if.word.ram_addr = base + cur.offs;
    end
  end

  assign out_if.ready = xfer_ready;

  dcr_skid_buf #(
    .DEPTH (2)
  ) u_buf (
    .clock (clock),
    .arst_n(arst_n),
    .fill  (push_if),
    .drain (out_if)
  );

  assign addr_take = hsel && htrans[1] && hready;

  // read mux; unimplemented bits come back zero through the masks
  always_comb begin
    rd_mux = '0;
    unique case (haddr[7:0])
      OFS_CONTROL: rd_mux[15:0] = cur.ctl & CTL_MASK;
      OFS_REQUEST: rd_mux[15:0] = cur.req & REQ_MASK;
      OFS_START_A: rd_mux[15:0] = cur.sta;
      OFS_START_B: rd_mux[15:0] = cur.stb;
      OFS_PERIPH:  rd_mux[15:0] = cur.pad;
      OFS_COUNT:   rd_mux[CNT_W-1:0] = cur.cnt;
      OFS_STATUS: begin
        rd_mux[0] = (cur.st == ST_RUN);
        rd_mux[1] = cur.sec;
        rd_mux[2] = cur.pend;
        rd_mux[STS_IDX_LO +: CNT_W] = cur.idx;
      end
      default:     rd_mux = '0;
    endcase
  end

  // sequencer first, bus writes last so software set beats hardware clear
  always_comb begin
    next_cur     = cur;
    next_cur.irq = 1'b0;
    next_cur.rdy = 1'b1;
    // remember a line request that this push does not serve; the set beats the clear,
    // since a push consumes the pending request first and the force bit second
    if (cur.st == ST_RUN && line_hit && (!push || cur.pend || cur.req[REQ_FORCE])) begin
      next_cur.pend = 1'b1;
    end else if (push) begin
      next_cur.pend = 1'b0;
    end
    unique case (cur.st)
      ST_IDLE: begin
        next_cur.idx  = '0;
        next_cur.offs = '0;
        next_cur.sec  = 1'b0;
        next_cur.pend = 1'b0;
        if (chen) begin
          next_cur.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!chen) begin
          next_cur.st = ST_IDLE;
        end
        if (push) begin
          // force is served only when no pending line request goes first
          if (!cur.pend) begin
            next_cur.req[REQ_FORCE] = 1'b0;
          end
          if (addressing_mode == AM_POSTINC) begin
            next_cur.offs = cur.offs + step;
          end
          next_cur.idx = cur.idx + 1'b1;
          if (early && half_pt) begin
            next_cur.irq = 1'b1;
          end
          if (last) begin
            next_cur.idx  = '0;
            next_cur.offs = '0;
            if (!early) begin
              next_cur.irq = 1'b1;
            end
            unique case (mode)
              OM_CONT:       next_cur.sec = 1'b0;
              OM_ONESHOT:    next_cur.ctl[CTL_ENABLE] = 1'b0;
              OM_CONT_PP:    next_cur.sec = ~cur.sec;
              OM_ONESHOT_PP: begin
                next_cur.sec = ~cur.sec;
                if (cur.sec) begin
                  next_cur.ctl[CTL_ENABLE] = 1'b0;
                end
              end
            endcase
          end
        end
      end
      default: next_cur.st = ST_IDLE;
    endcase
    // ahb data phase write
    next_cur.wr_pend = addr_take && hwrite;
    if (addr_take) begin
      next_cur.wr_addr = haddr[7:0];
      next_cur.rdata   = rd_mux;
    end
    if (cur.wr_pend) begin
      unique case (cur.wr_addr)
        OFS_CONTROL: next_cur.ctl = wdata & CTL_MASK;
        OFS_REQUEST: begin
          next_cur.req[6:0] = wdata[6:0];
          if (wdata[REQ_FORCE]) begin
            next_cur.req[REQ_FORCE] = 1'b1;
          end
        end
        OFS_START_A: next_cur.sta = wdata;
        OFS_START_B: next_cur.stb = wdata;
        OFS_PERIPH:  next_cur.pad = wdata;
        OFS_COUNT:   next_cur.cnt = wdata[CNT_W-1:0];
        default:     next_cur.rdy = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs from flops
  assign hrdata           = cur.rdata;
  assign hreadyout        = cur.rdy;
  assign hresp            = 1'b0;
  assign block_irq        = cur.irq;
  assign xfer_valid       = out_if.valid;
  assign xfer_ram_addr    = out_if.word.ram_addr;
  assign xfer_periph_addr = out_if.word.periph_addr;
  assign xfer_to_periph   = out_if.word.to_periph;
  assign xfer_null_write  = out_if.word.null_write;
  assign xfer_byte        = out_if.word.byte_size;

  // checks
  default clocking dcr_cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_last_push;
    push && last && !ctl_wr;
  endsequence

  sequence s_half_push;
    push && early && half_pt;
  endsequence

  a_ctl_unimpl_zero: assert property ((cur.ctl & ~CTL_MASK) == '0)
    else $error("unimplemented control bits set");

  a_req_unimpl_zero: assert property (cur.req[14:7] == '0)
    else $error("unimplemented request bits set");

  a_force_self_clear: assert property (push && !cur.pend && !req_wr
                                       |=> !cur.req[REQ_FORCE])
    else $error("force bit not cleared after transfer");

  a_force_holds: assert property (cur.req[REQ_FORCE] && !push |=> cur.req[REQ_FORCE])
    else $error("force bit lost without a transfer");

  a_full_block_irq: assert property (s_last_push ##0 !early |=> block_irq ##1 !block_irq)
    else $error("end of block interrupt missing");

  a_half_block_irq: assert property (s_half_push |=> block_irq)
    else $error("half block interrupt missing");

  a_oneshot_stop: assert property (s_last_push ##0 (mode == OM_ONESHOT) |=> !chen)
    else $error("one-shot channel still enabled");

  a_pingpong_swap: assert property (s_last_push ##0 (mode == OM_CONT_PP)
                                    |=> cur.sec != $past(cur.sec))
    else $error("buffer not swapped");

  a_pp_oneshot_stop: assert property (s_last_push ##0 (mode == OM_ONESHOT_PP) ##0 cur.sec
                                      |=> !chen && !cur.sec)
    else $error("ping-pong one-shot did not stop");

  a_null_flag: assert property (push |-> push_if.word.null_write ==
                                (cur.ctl[CTL_NULL_PERIPHERAL_WRITE] && !cur.ctl[CTL_TO_PER]))
    else $error("null write flag wrong");

  a_post_increment: assert property (push && !last && addressing_mode == AM_POSTINC
                                     |=> cur.offs == $past(cur.offs) + $past(step))
    else $error("ram offset not advanced");

  a_idle_no_push: assert property (!chen && !$past(chen) |-> !push)
    else $error("transfer while channel disabled");

  a_null_dir: assert property (xfer_valid && xfer_to_periph |-> !xfer_null_write)
    else $error("null write offered towards the peripheral");

  a_pend_set_wins: assert property (cur.st == ST_RUN && line_hit && cur.pend |=> cur.pend)
    else $error("line request lost while one was pending");

  a_noinc_hold: assert property (push && !last && addressing_mode == AM_NOINC
                                 |=> cur.offs == $past(cur.offs))
    else $error("ram offset moved without post-increment");

endmodule

// ### dcr_periph_model.sv
// dcr_periph_model: peripheral-side sink of transfer words, prompt, slow or stalled
// assumes the channel holds each word steady while valid is high and ready low
`timescale 1ns/10ps
module dcr_periph_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // pacing: 0 prompt, 1 every other cycle, 2 stalled
  input  wire logic [1:0]  pace,
  // transfer words from the channel
  input  wire logic        xfer_valid,
  input  wire logic [15:0] xfer_ram_addr,
  input  wire logic        xfer_null_write,
  output      logic        xfer_ready
);
  logic [15:0] got_addr[$];
  logic        got_null[$];
  logic        phase;

  // slow pacing gives the buffer real back-pressure, not just a stall
  assign xfer_ready = (pace == 2'h0) | ((pace == 2'h1) & phase);

  // record every accepted word in arrival order
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      if (xfer_valid && xfer_ready) begin
        got_addr.push_back(xfer_ram_addr);
        got_null.push_back(xfer_null_write);
      end
    end
  end
endmodule

// ### dcr_channel_tb_top.sv
// dcr_channel_tb_top: self-checking bench for one dma channel
// assumes zero-wait ahb-lite registers and a peripheral sink model
`timescale 1ns/10ps
module dcr_channel_tb_top;
  import dcr_pkg::*;
  logic         clock    = 1'b0;
  logic         arst_n   = 1'b0;
  logic         hsel     = 1'b0;
  logic         hwrite   = 1'b0;
  logic [1:0]   htrans   = 2'h0;
  logic [1:0]   pace     = 2'h0;
  logic [31:0]  haddr    = 32'h0;
  logic [31:0]  hwdata   = 32'h0;
  logic [127:0] lines    = '0;
  logic [31:0]  hrdata;
  logic [31:0]  rdv;
  logic         hreadyout;
  logic         hresp;
  logic         xv;
  logic         xr;
  logic         xnull;
  logic         irq;
  logic [15:0]  xaddr;
  logic [15:0]  xpad;
  logic         xto;
  logic         xbyte;
  int           failures = 0;
  int           n_checks = 0;
  int           cycles   = 0;
  int           irq_n    = 0;

  dcr_channel u_dcr_channel (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .peripheral_request_line(lines), .periph_index(16'h0040),
    .xfer_valid(xv), .xfer_ready(xr), .xfer_ram_addr(xaddr), .xfer_periph_addr(xpad),
    .xfer_to_periph(xto), .xfer_null_write(xnull), .xfer_byte(xbyte), .block_irq(irq)
  );

  dcr_periph_model u_dcr_periph_model (
    .clock(clock), .arst_n(arst_n), .pace(pace), .xfer_valid(xv),
    .xfer_ram_addr(xaddr), .xfer_null_write(xnull), .xfer_ready(xr)
  );

  // clock, irq pulse count and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single-word transfer; address held until hready seen high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ahb(1'b1, a, {16'h0000, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rdv, {16'h0000, exp});
  endtask

  // one-cycle request pulses, spaced so the slow sink keeps up
  task automatic fire(input int idx, input int n);
    repeat (n) begin
      lines[idx] <= 1'b1;
      @(posedge clock);
      lines <= '0;
      repeat (3) @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask

  // disable, program a four-transfer block, then write control last
  task automatic setup(input logic [15:0] ctl, input logic [15:0] req);
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_START_A, 16'h0100);
    wr(OFS_START_B, 16'h0200);
    wr(OFS_COUNT, 16'h0003);
    wr(OFS_REQUEST, req);
    u_dcr_periph_model.got_addr.delete();
    u_dcr_periph_model.got_null.delete();
    irq_n = 0;
    wr(OFS_CONTROL, ctl);
    repeat (3) @(posedge clock);
  endtask

  function automatic logic [15:0] exp_addr(input int m, input int k);
    logic [15:0] base;
    base = (m >= 2 && (k / 4) % 2 == 1) ? 16'h0200 : 16'h0100;
    return base + 16'(2 * (k % 4));
  endfunction

  task automatic t_regs;
    for (int a = 0; a <= 8'h18; a += 4) rd(8'(a), REG_RESET);
    rd(8'h40, 16'h0000);
    wr(OFS_CONTROL, 16'hffff);
    rd(OFS_CONTROL, 16'hf833);
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_REQUEST, 16'h7fff);
    rd(OFS_REQUEST, 16'h007f);
    wr(OFS_REQUEST, 16'h0000);
    chk(hresp, 1'b0);
    $display("t_regs done");
  endtask

  task automatic t_modes;
    int nexp;
    for (int m = 0; m < 4; m++) begin
      pace <= 2'(m >> 1);
      setup(16'h8000 | 16'(m), 16'h0005);
      fire(5, 10);
      nexp = (m == 1) ? 4 : (m == 3) ? 8 : 10;
      chk(u_dcr_periph_model.got_addr.size(), nexp);
      for (int k = 0; k < nexp; k++)
        chk(u_dcr_periph_model.got_addr[k], exp_addr(m, k));
      chk(irq_n, nexp / 4);
      rd(OFS_CONTROL, (m % 2 == 1) ? 16'(m) : 16'h8000 | 16'(m));
    end
    pace <= 2'h0;
    $display("t_modes done");
  endtask

  // sink stalled: two words buffered, a third held as one pending request
  task automatic t_stall;
    pace <= 2'h2;
    wr(OFS_PERIPH, 16'h0a5c);
    // byte steps towards the peripheral, so ram address, peripheral address, direction and byte size are seen while it stands
    setup(16'he001, 16'h0005);
    fire(5, 4);
    chk(xv, 1'b1);
    chk(xaddr, 16'h0100);
    chk(xpad, 16'h0a5c);
    chk(xto, 1'b1);
    chk(xbyte, 1'b1);
    chk(u_dcr_periph_model.got_addr.size(), 0);
    // running, one request pending, two transfers issued
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rdv, 32'h00020005);
    pace <= 2'h0;
    repeat (10) @(posedge clock);
    chk(u_dcr_periph_model.got_addr.size(), 3);
    for (int k = 0; k < 3; k++)
      chk(u_dcr_periph_model.got_addr[k], 16'h0100 + 16'(k));
    $display("t_stall done");
  endtask

  task automatic t_force;
    setup(16'h0000, 16'h8009);
    rd(OFS_REQUEST, 16'h8009);
    wr(OFS_REQUEST, 16'h0009);
    rd(OFS_REQUEST, 16'h8009);
    wr(OFS_CONTROL, 16'h8001);
    repeat (10) @(posedge clock);
    chk(u_dcr_periph_model.got_addr.size(), 1);
    rd(OFS_REQUEST, 16'h0009);
    $display("t_force done");
  endtask

  task automatic t_addressing_mode;
    for (int am = 0; am < 4; am++) begin
      setup(16'h8001 | 16'(am << 4), 16'h0005);
      fire(5, 2);
      for (int k = 0; k < 2; k++)
        chk(u_dcr_periph_model.got_addr[k], (am == 0) ? 16'h0100 + 16'(2 * k) :
            (am == 2) ? 16'h0140 : 16'h0100);
    end
    $display("t_addressing_mode done");
  endtask

  task automatic t_null_sel;
    setup(16'h8801, 16'h0005);
    fire(5, 1);
    chk(u_dcr_periph_model.got_null[0], 1'b1);
    setup(16'ha801, 16'h0005);
    fire(5, 1);
    chk(u_dcr_periph_model.got_null[0], 1'b0);
    setup(16'h8001, 16'h007f);
    fire(126, 2);
    chk(u_dcr_periph_model.got_addr.size(), 0);
    fire(127, 1);
    chk(u_dcr_periph_model.got_addr.size(), 1);
    $display("t_null_sel done");
  endtask

  task automatic t_early;
    for (int e = 0; e < 2; e++) begin
      setup(16'h8001 | 16'(e << 12), 16'h0005);
      fire(5, 2);
      chk(irq_n, e);
      fire(5, 2);
      chk(irq_n, 1);
    end
    $display("t_early done");
  endtask

  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_modes();
    t_stall();
    t_force();
    t_addressing_mode();
    t_null_sel();
    t_early();
    end_of_test();
  end
endmodule
